// file: dv/iak_core_model.sv
`timescale 1ns/100ps
// core stand-in: fixed-length instructions, pc steps by 2 each one
module iak_core_model #(
  parameter int LEN = 4
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rstn,
  input  wire logic                       i_stall,
  input  wire logic                       i_push_valid,
  input  wire logic [iak_pkg::DATA_W-1:0] i_push_data,
  input  wire logic                       i_vec_load,
  input  wire logic [iak_pkg::PC_W-1:0]   i_vec_addr,
  output logic                            o_last,
  output logic      [iak_pkg::PC_W-1:0]   o_pc,
  output logic      [iak_pkg::PC_W-1:0]   o_ret_pc,
  output logic      [23:0]                o_pushed
);
  int cnt;
  // no boundary while the entry sequence owns the core
  assign o_last = (cnt == LEN - 1) && !i_stall;
  always @(posedge i_clk) begin
    if (!i_rstn || i_stall) begin
      cnt <= 0;
    end else begin
      cnt <= (cnt == LEN - 1) ? 0 : cnt + 1;
    end
    if (!i_rstn) begin
      o_pc     <= 16'h1230;
      o_ret_pc <= 16'h0000;
      o_pushed <= 24'h000000;
    end else begin
      if (i_vec_load) begin
        o_pc <= i_vec_addr;
      end else if (o_last) begin
        o_ret_pc <= o_pc;
        o_pc     <= o_pc + 16'h0002;
      end
      // stack bytes kept in arrival order
      if (i_push_valid) begin
        o_pushed <= {o_pushed[15:0], i_push_data};
      end
    end
  end
endmodule : iak_core_model

// file: dv/tb.sv
`timescale 1ns/100ps
module tb;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  i_src_event = 8'h00;
  logic        i_nmi_event = 1'b0;
  logic        i_ei = 1'b0;
  logic        i_di = 1'b0;
  logic        i_return_from_interrupt_instr = 1'b0;
  logic [7:0]  i_return_from_interrupt_instr_psw = 8'h00;
  logic [7:0]  o_rdata, o_push_data, o_psw;
  logic [15:0] o_vec_addr, pc, ret_pc;
  logic [23:0] pushed;
  logic        o_stall, o_push_valid, o_vec_load, o_in_nmi, last;
  int          n_mismatch = 0;
  int          checked = 0;
  int          n_vec = 0;
  int          lat = 0;
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_vec_load === 1'b1) n_vec <= n_vec + 1;
  iak_top i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_src_event(i_src_event), .i_nmi_event(i_nmi_event),
    .i_instr_last(last), .i_ei(i_ei), .i_di(i_di), .i_return_from_interrupt_instr(i_return_from_interrupt_instr),
    .i_return_from_interrupt_instr_psw(i_return_from_interrupt_instr_psw), .i_pc(pc), .o_stall(o_stall),
    .o_push_valid(o_push_valid), .o_push_data(o_push_data),
    .o_vec_load(o_vec_load), .o_vec_addr(o_vec_addr), .o_psw(o_psw),
    .o_in_nmi(o_in_nmi));
  iak_core_model #(.LEN(4)) i_core (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_stall(o_stall), .i_push_valid(o_push_valid),
    .i_push_data(o_push_data), .i_vec_load(o_vec_load),
    .i_vec_addr(o_vec_addr), .o_last(last), .o_pc(pc),
    .o_ret_pc(ret_pc), .o_pushed(pushed));
  task results;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    cmp("rdata", {16'h0000, e}, {16'h0000, o_rdata});
  endtask : rd
  task ev(input logic [7:0] s, input logic n);
    @(posedge i_clk);
    i_src_event <= s; i_nmi_event <= n;
    @(posedge i_clk);
    i_src_event <= 8'h00; i_nmi_event <= 1'b0;
  endtask : ev
  task ctl(input logic e, input logic d, input logic r, input logic [7:0] w);
    @(posedge i_clk);
    i_ei <= e; i_di <= d; i_return_from_interrupt_instr <= r; i_return_from_interrupt_instr_psw <= w;
    @(posedge i_clk);
    i_ei <= 1'b0; i_di <= 1'b0; i_return_from_interrupt_instr <= 1'b0;
  endtask : ctl
  // bounded wait for the vector load, then check stack bytes and enable
  task wait_vec(input logic [15:0] va, input logic [7:0] w);
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      #1;
      k++;
    end while (o_vec_load !== 1'b1 && k < 40);
    lat = k;
    cmp("latency_ok", 24'h1, {23'h0, k <= 19});
    cmp("vec_addr", {8'h00, va}, {8'h00, o_vec_addr});
    cmp("stack", {w, ret_pc}, pushed);
    cmp("stall", 24'h1, {23'h0, o_stall});
    cmp("push_valid", 24'h0, {23'h0, o_push_valid});
    @(posedge i_clk);
    #1;
    cmp("irq_enable", 24'h0, {23'h0, o_psw[7]});
    cmp("stall", 24'h0, {23'h0, o_stall});
  endtask : wait_vec
  // park in the last clock of an instruction, then let d more edges pass
  task align(input int d);
    do begin
      @(posedge i_clk);
      #1;
    end while (last !== 1'b1);
    repeat (d) @(posedge i_clk);
  endtask : align
  initial begin
    repeat (4000) @(posedge i_clk);
    n_mismatch++;
    results();
  end
  initial begin
    int n0;
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(iak_pkg::ADDR_PSW, 8'h02);
    rd(iak_pkg::ADDR_REQ, 8'h00);
    rd(iak_pkg::ADDR_MASK, 8'hFF);
    rd(iak_pkg::ADDR_PRIO, 8'hFF);
    rd(iak_pkg::ADDR_STAT, 8'h00);
    wr(4'h7, 8'hFF);
    rd(4'h7, 8'h00);
    $display("test reset_map done");
    ev(8'h04, 1'b0);
    ctl(1'b1, 1'b0, 1'b0, 8'h00);
    n0 = n_vec;
    repeat (20) @(posedge i_clk);
    cmp("vec_count", 24'(n0), 24'(n_vec));
    rd(iak_pkg::ADDR_REQ, 8'h04);
    ctl(1'b0, 1'b1, 1'b0, 8'h00);
    rd(iak_pkg::ADDR_PSW, 8'h02);
    wr(iak_pkg::ADDR_MASK, 8'hFB);
    repeat (20) @(posedge i_clk);
    cmp("vec_count", 24'(n0), 24'(n_vec));
    // enable lands while every instruction touches the mask register
    fork
      repeat (10) rd(iak_pkg::ADDR_MASK, 8'hFB);
      begin
        repeat (3) @(posedge i_clk);
        ctl(1'b1, 1'b0, 1'b0, 8'h00);
      end
    join
    cmp("vec_count", 24'(n0), 24'(n_vec));
    wait_vec(16'h000A, 8'h82);
    rd(iak_pkg::ADDR_REQ, 8'h00);
    $display("test enable_mask done");
    wr(iak_pkg::ADDR_PRIO, 8'hDF);
    wr(iak_pkg::ADDR_MASK, 8'h00);
    ev(8'h22, 1'b0);
    n0 = n_vec;
    repeat (20) @(posedge i_clk);
    cmp("vec_count", 24'(n0), 24'(n_vec));
    ctl(1'b0, 1'b0, 1'b1, 8'h82);
    wait_vec(16'h0010, 8'h82);
    ctl(1'b0, 1'b0, 1'b1, 8'h82);
    wait_vec(16'h0008, 8'h82);
    wr(iak_pkg::ADDR_PRIO, 8'hFF);
    ctl(1'b0, 1'b0, 1'b1, 8'h82);
    ev(8'h48, 1'b0);
    wait_vec(16'h000C, 8'h82);
    $display("test priority done");
    ev(8'h00, 1'b1);
    wait_vec(16'h0004, 8'h02);
    cmp("in_nmi", 24'h1, {23'h0, o_in_nmi});
    ev(8'h00, 1'b1);
    wait_vec(16'h0004, 8'h02);
    ctl(1'b0, 1'b0, 1'b1, 8'h82);
    #1;
    cmp("in_nmi", 24'h0, {23'h0, o_in_nmi});
    wait_vec(16'h0012, 8'h82);
    ctl(1'b0, 1'b0, 1'b1, 8'h82);
    ev(8'h01, 1'b1);
    wait_vec(16'h0004, 8'h82);
    rd(iak_pkg::ADDR_REQ, 8'h01);
    $display("test nonmaskable done");
    ctl(1'b0, 1'b0, 1'b1, 8'h82);
    wait_vec(16'h0006, 8'h82);
    // flag up by clock n-1 is taken at this boundary, five edges to vector
    ctl(1'b0, 1'b0, 1'b1, 8'h82);
    align(1);
    ev(8'h80, 1'b0);
    wait_vec(16'h0014, 8'h82);
    cmp("latency", 24'h5, 24'(lat));
    // flag up in the last clock waits one whole instruction more
    ctl(1'b0, 1'b0, 1'b1, 8'h82);
    align(2);
    ev(8'h10, 1'b0);
    wait_vec(16'h000E, 8'h82);
    cmp("latency", 24'h8, 24'(lat));
    $display("test boundary done");
    results();
  end
endmodule : tb

// file: pkg/iak_pkg.sv
package iak_pkg;
  localparam int          SRC_N        = 8;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 4;
  localparam int          PC_W         = 16;
  localparam int          IDX_W        = 3;
  // register word addresses
  localparam logic [3:0]  ADDR_PSW     = 4'h0;
  localparam logic [3:0]  ADDR_REQ     = 4'h1;
  localparam logic [3:0]  ADDR_MASK    = 4'h2;
  localparam logic [3:0]  ADDR_PRIO    = 4'h3;
  localparam logic [3:0]  ADDR_STAT    = 4'h4;
  // values after reset, and the enable bit position
  localparam logic [7:0]  PSW_RST      = 8'h02;
  localparam logic [7:0]  REQ_RST      = 8'h00;
  localparam logic [7:0]  MASK_RST     = 8'hFF;
  localparam logic [7:0]  PRIO_RST     = 8'hFF;
  localparam int          PSW_IE_BIT   = 7;
  // vector table entries
  localparam logic [15:0] NMI_VEC      = 16'h0004;
  localparam logic [15:0] MSK_VEC_BASE = 16'h0006;
  // maskable latency window in cpu clocks, and own sequence length
  localparam int          LAT_MIN_CLK  = 9;
  localparam int          LAT_MAX_CLK  = 19;
  localparam int          SEQ_CLK      = 4;

  typedef enum logic [2:0] {
    IAK_IDLE     = 3'b000,
    IAK_PUSH_PSW = 3'b001,
    IAK_PUSH_PCH = 3'b010,
    IAK_PUSH_PCL = 3'b011,
    IAK_LOAD_VEC = 3'b100
  } iak_state_t;
endpackage : iak_pkg

// file: pkg/iak_sel_if.sv
`timescale 1ns/100ps
interface iak_sel_if;
  logic [iak_pkg::SRC_N-1:0] elig;
  logic [iak_pkg::SRC_N-1:0] prio;
  logic                      valid;
  logic [iak_pkg::IDX_W-1:0] idx;
  modport sel  (input elig, input prio, output valid, output idx);
  modport user (output elig, output prio, input valid, input idx);
endinterface : iak_sel_if

// file: rtl/iak_prio_sel.sv
`timescale 1ns/100ps
// picks one eligible source: priority flag 0 ranks high, ties go to the
// lowest source number
module iak_prio_sel (
  iak_sel_if.sel s
);
  logic [iak_pkg::SRC_N-1:0] hi_set;
  logic [iak_pkg::SRC_N-1:0] pool;

  assign hi_set = s.elig & ~s.prio;
  assign pool   = (hi_set != '0) ? hi_set : s.elig;

  always_comb begin
    s.valid = (s.elig != '0);
    s.idx   = '0;
    // scan downward so the lowest number is written last and wins
    for (int i = iak_pkg::SRC_N - 1; i >= 0; i--) begin
      if (pool[i]) begin
        s.idx = iak_pkg::IDX_W'(i);
      end
    end
  end
endmodule : iak_prio_sel

// file: rtl/iak_top.sv
`timescale 1ns/100ps
// Functional notes
// - non-maskable request is taken even with the global enable clear
// - non-maskable request skips priority and beats every maskable one
// - non-maskable entry pushes status word, then pc, clears enable, vectors
// - a new non-maskable request preempts a running non-maskable routine
// - maskable source eligible only with request flag 1 and mask flag 0
// - maskable vectoring only while the global enable bit is 1
// - maskable service starts 9 to 19 cpu clocks after the request; here a flag set in clock n-1 gets its vector load 5 clocks later
// - worst latency when request lands just before a bit-test branch
// - highest programmed priority among eligible sources is taken first
// - unaccepted requests stay pending and are taken once allowed
// - maskable entry pushes status word, pc, clears enable, own vector
// - return-from-interrupt instruction ends a routine and restores state
// - flag set by clock n-1 is taken right after the instruction
// - flag set in the last clock waits one more whole instruction
// - access to flag or mask registers defers all requests one instruction
// - maskable nesting only after enable set again, else pending until return
// - enable bit lives in the 8-bit status word, reset value 02H
// - mask flag 0 enables its source, 1 disables it
// - enable and disable instructions set and clear the global enable
module iak_top (
  input  wire logic                        i_clk,
  input  wire logic                        i_rstn,
  input  wire logic [iak_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [iak_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [iak_pkg::DATA_W-1:0]  o_rdata,
  input  wire logic [iak_pkg::SRC_N-1:0]   i_src_event,
  input  wire logic                        i_nmi_event,
  input  wire logic                        i_instr_last,
  input  wire logic                        i_ei,
  input  wire logic                        i_di,
  input  wire logic                        i_return_from_interrupt_instr,
  input  wire logic [iak_pkg::DATA_W-1:0]  i_return_from_interrupt_instr_psw,
  input  wire logic [iak_pkg::PC_W-1:0]    i_pc,
  output logic                             o_stall,
  output logic                             o_push_valid,
  output logic      [iak_pkg::DATA_W-1:0]  o_push_data,
  output logic                             o_vec_load,
  output logic      [iak_pkg::PC_W-1:0]    o_vec_addr,
  output logic      [iak_pkg::DATA_W-1:0]  o_psw,
  output logic                             o_in_nmi
);
  iak_pkg::iak_state_t              state;
  iak_pkg::iak_state_t              next_state;
  logic [iak_pkg::DATA_W-1:0]       next_psw;
  logic [iak_pkg::SRC_N-1:0]        req;
  logic [iak_pkg::SRC_N-1:0]        next_req;
  logic [iak_pkg::SRC_N-1:0]        mask;
  logic [iak_pkg::SRC_N-1:0]        next_mask;
  logic [iak_pkg::SRC_N-1:0]        prio;
  logic [iak_pkg::SRC_N-1:0]        next_prio;
  logic [iak_pkg::SRC_N-1:0]        elig_q;
  logic [iak_pkg::SRC_N-1:0]        next_elig_q;
  logic                             nmi_pend;
  logic                             next_nmi_pend;
  logic                             nmi_q;
  logic                             next_nmi_q;
  logic                             hold;
  logic                             next_hold;
  logic [iak_pkg::PC_W-1:0]         pc_save;
  logic [iak_pkg::PC_W-1:0]         next_pc_save;
  logic [iak_pkg::IDX_W-1:0]        acc_idx;
  logic [iak_pkg::IDX_W-1:0]        next_acc_idx;
  logic [iak_pkg::DATA_W-1:0]       next_rdata;
  logic                             next_stall;
  logic                             next_push_valid;
  logic [iak_pkg::DATA_W-1:0]       next_push_data;
  logic                             next_vec_load;
  logic [iak_pkg::PC_W-1:0]         next_vec_addr;
  logic                             next_in_nmi;
  logic [iak_pkg::SRC_N-1:0]        elig_now;
  logic                             flag_acc;
  logic                             boundary;
  logic                             block;
  logic                             take_nmi;
  logic                             take_msk;
  logic                             ie;

  iak_sel_if sel_bus ();

  iak_prio_sel u_sel (
    .s (sel_bus.sel)
  );

  assign ie       = o_psw[iak_pkg::PSW_IE_BIT];
  assign elig_now = req & ~mask;
  // a source counts only if it was already eligible one clock earlier, so a
  // flag that rises in the last clock misses this boundary
  assign sel_bus.elig = elig_q & elig_now;
  assign sel_bus.prio = prio;
  assign flag_acc = (i_wr || i_rd) &&
                    (i_addr == iak_pkg::ADDR_REQ ||
                     i_addr == iak_pkg::ADDR_MASK);
  assign boundary = i_instr_last && (state == iak_pkg::IAK_IDLE);
  assign block    = hold || flag_acc;
  // the enable bit is not looked at here, and neither is o_in_nmi
  assign take_nmi = boundary && !block && nmi_q && nmi_pend;
  assign take_msk = boundary && !block && !take_nmi && ie &&
                    sel_bus.valid;

  // acceptance, servicing sequence and software-visible state
  always_comb begin
    next_state      = state;
    next_psw        = o_psw;
    next_req        = req;
    next_mask       = mask;
    next_prio       = prio;
    next_elig_q     = elig_now;
    next_nmi_q      = nmi_pend;
    next_nmi_pend   = nmi_pend;
    next_hold       = hold;
    next_pc_save    = pc_save;
    next_acc_idx    = acc_idx;
    next_vec_addr   = o_vec_addr;
    next_in_nmi     = o_in_nmi;
    next_push_data  = o_push_data;
    next_rdata      = '0;

    // deferral lasts to the end of the accessing instruction only
    if (flag_acc) begin
      next_hold = 1'b1;
    end
    if (boundary) begin
      next_hold = 1'b0;
    end

    if (i_wr) begin
      case (i_addr)
        iak_pkg::ADDR_PSW:  next_psw  = i_wdata;
        iak_pkg::ADDR_REQ:  next_req  = i_wdata;
        iak_pkg::ADDR_MASK: next_mask = i_wdata;
        iak_pkg::ADDR_PRIO: next_prio = i_wdata;
        default:            next_rdata = '0;
      endcase
    end
    if (i_ei) begin
      next_psw[iak_pkg::PSW_IE_BIT] = 1'b1;
    end
    if (i_di) begin
      next_psw[iak_pkg::PSW_IE_BIT] = 1'b0;
    end
    if (i_return_from_interrupt_instr) begin
      next_psw    = i_return_from_interrupt_instr_psw;
      next_in_nmi = 1'b0;
    end

    if (take_nmi) begin
      next_nmi_pend = 1'b0;
      next_in_nmi   = 1'b1;
      next_vec_addr = iak_pkg::NMI_VEC;
    end
    if (take_msk) begin
      next_req[sel_bus.idx] = 1'b0;
      next_acc_idx  = sel_bus.idx;
      next_vec_addr = iak_pkg::MSK_VEC_BASE +
                      {12'h000, sel_bus.idx, 1'b0};
    end
    // a new event in the clearing cycle survives
    next_req      = next_req | i_src_event;
    next_nmi_pend = next_nmi_pend | i_nmi_event;

    case (state)
      iak_pkg::IAK_IDLE: begin
        if (take_nmi || take_msk) begin
          next_state     = iak_pkg::IAK_PUSH_PSW;
          next_pc_save   = i_pc;
          next_push_data = o_psw;
        end
      end
      iak_pkg::IAK_PUSH_PSW: begin
        next_state     = iak_pkg::IAK_PUSH_PCH;
        next_push_data = pc_save[15:8];
      end
      iak_pkg::IAK_PUSH_PCH: begin
        next_state     = iak_pkg::IAK_PUSH_PCL;
        next_push_data = pc_save[7:0];
      end
      iak_pkg::IAK_PUSH_PCL: begin
        next_state = iak_pkg::IAK_LOAD_VEC;
      end
      iak_pkg::IAK_LOAD_VEC: begin
        // clear last so it overrides any software write in the same cycle
        next_psw[iak_pkg::PSW_IE_BIT] = 1'b0;
        next_state = iak_pkg::IAK_IDLE;
      end
      default: begin
        next_state = iak_pkg::IAK_IDLE;
      end
    endcase

    next_stall      = (next_state != iak_pkg::IAK_IDLE);
    next_push_valid = (next_state == iak_pkg::IAK_PUSH_PSW) ||
                      (next_state == iak_pkg::IAK_PUSH_PCH) ||
                      (next_state == iak_pkg::IAK_PUSH_PCL);
    next_vec_load   = (next_state == iak_pkg::IAK_LOAD_VEC);

    if (i_rd) begin
      case (i_addr)
        iak_pkg::ADDR_PSW:  next_rdata = o_psw;
        iak_pkg::ADDR_REQ:  next_rdata = req;
        iak_pkg::ADDR_MASK: next_rdata = mask;
        iak_pkg::ADDR_PRIO: next_rdata = prio;
        iak_pkg::ADDR_STAT: next_rdata = {o_in_nmi, nmi_pend, hold, 2'b00,
                                          state};
        default:            next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state        <= iak_pkg::IAK_IDLE;
      o_psw        <= iak_pkg::PSW_RST;
      req          <= iak_pkg::REQ_RST;
      mask         <= iak_pkg::MASK_RST;
      prio         <= iak_pkg::PRIO_RST;
      elig_q       <= '0;
      nmi_pend     <= 1'b0;
      nmi_q        <= 1'b0;
      hold         <= 1'b0;
      pc_save      <= '0;
      acc_idx      <= '0;
      o_rdata      <= '0;
      o_stall      <= 1'b0;
      o_push_valid <= 1'b0;
      o_push_data  <= '0;
      o_vec_load   <= 1'b0;
      o_vec_addr   <= '0;
      o_in_nmi     <= 1'b0;
    end else begin
      state        <= next_state;
      o_psw        <= next_psw;
      req          <= next_req;
      mask         <= next_mask;
      prio         <= next_prio;
      elig_q       <= next_elig_q;
      nmi_pend     <= next_nmi_pend;
      nmi_q        <= next_nmi_q;
      hold         <= next_hold;
      pc_save      <= next_pc_save;
      acc_idx      <= next_acc_idx;
      o_rdata      <= next_rdata;
      o_stall      <= next_stall;
      o_push_valid <= next_push_valid;
      o_push_data  <= next_push_data;
      o_vec_load   <= next_vec_load;
      o_vec_addr   <= next_vec_addr;
      o_in_nmi     <= next_in_nmi;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_NMI_NO_IE: assert property (
    (boundary && !block && nmi_q && nmi_pend && !ie)
      |=> state == iak_pkg::IAK_PUSH_PSW
  ) else $error("nmi not taken with enable clear");

  AST_NMI_FIRST: assert property (
    (boundary && !block && nmi_q && nmi_pend && ie && sel_bus.valid)
      |=> (o_vec_addr == iak_pkg::NMI_VEC) && o_in_nmi
  ) else $error("maskable request beat a pending nmi");

  AST_PUSH_ORDER: assert property (
    (take_nmi || take_msk)
      |=> o_push_valid && o_push_data == $past(o_psw)
      ##1 o_push_valid && o_push_data == pc_save[15:8]
      ##1 o_push_valid && o_push_data == pc_save[7:0]
      ##1 o_vec_load && !o_push_valid
  ) else $error("entry sequence out of order");

  AST_IE_CLR: assert property (
    o_vec_load |=> !ie && !o_stall
  ) else $error("enable bit not cleared at vector load");

  AST_ELIG: assert property (
    take_msk |-> req[sel_bus.idx] && !mask[sel_bus.idx]
  ) else $error("ineligible source accepted");

  AST_IE_GATE: assert property (
    (boundary && !ie && !(nmi_q && nmi_pend))
      |=> state == iak_pkg::IAK_IDLE
  ) else $error("maskable taken with enable clear");

  AST_SEQ_LEN: assert property (
    take_msk |-> ##4 o_vec_load &&
      o_vec_addr == iak_pkg::MSK_VEC_BASE + {12'h000, acc_idx, 1'b0}
  ) else $error("maskable vector late or wrong");

  AST_PRIO: assert property (
    (take_msk && ((sel_bus.elig & ~prio) != '0)) |-> !prio[sel_bus.idx]
  ) else $error("low priority source beat high priority one");

  AST_FLAG_CLR: assert property (
    (take_msk && !i_src_event[sel_bus.idx]) |=> !req[acc_idx]
  ) else $error("accepted request flag not cleared");

  AST_HOLD: assert property (
    (boundary && flag_acc) |=> state == iak_pkg::IAK_IDLE && !hold
  ) else $error("request taken during flag register access");

  AST_LATE: assert property (
    (boundary && elig_q == '0 && !nmi_q) |=> state == iak_pkg::IAK_IDLE
  ) else $error("request set in last clock taken early");
endmodule : iak_top
